// ### hw/ebp_pwm.sv
// Overview of operation
// - duty is duty_high_byte as upper eight bits, control bits 5:4 lower two
// - duty writes allowed anytime; shadow loads only at period match
// - shadow register ignores software writes while pwm mode selected
// - output clears when shadow plus latch equals timer with sub bits
// - duty beyond period never clears the output in that period
// - config 00 single, 10 half, 01 full forward, 11 full reverse
// - half-bridge drives pwm on A and its complement on B
// - half-bridge delays each rising edge by deadband count instruction cycles
// - deadband longer than active time keeps that output inactive
// - forward holds A active, modulates D; reverse holds C, modulates B
// - upper config bit sets direction, taking effect next pwm cycle
// - on direction change unmodulated outputs switch one timer tick early
// - from that switch to period start, B and D stay inactive
// - full-bridge has no deadband delay, even at direction change
// - prescale ratio 1, 4 or 16 from timer control bits 1:0
// - after timer equals limit: clear timer, set output unless zero, load
// - mode 11xx: bit 1 inverts A and C, bit 0 inverts B and D
// - controls load at period start; deadband at duty or period boundary
`timescale 1ns/1ps
`default_nettype none
module ebp_pwm (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             pwm_out_a,
    output logic             pwm_out_b,
    output logic             pwm_out_c,
    output logic             pwm_out_d,
    output logic             pwm_oe_a,
    output logic             pwm_oe_b,
    output logic             pwm_oe_c,
    output logic             pwm_oe_d
);
    logic [7:0]        duty_high_q;
    logic [7:0]        ctrl_q;
    logic [7:0]        period_q;
    logic [2:0]        tcon_q;
    logic [7:0]        dband_q;
    logic [7:0]        shadow_q;
    logic [1:0]        lsb_q;
    ebp_pkg::ebp_cfg_e cfg_act_q;
    logic [3:0]        mode_act_q;
    logic [6:0]        dband_act_q;
    logic              raw_q;
    logic              early_q;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [7:0]        timer;
    logic [1:0]        sub;
    logic              last_tick;
    logic              pstart;
    logic              db_a;
    logic              db_b;
    logic              wr_en;
    logic              pwm_sel;
    logic              pwm_on;
    logic              fb_turn;
    logic              duty_match;
    logic [9:0]        duty_ext;
    logic [9:0]        duty_next;
    logic [9:0]        cnt_ext;
    logic [3:0]        lvl;
    logic [3:0]        en;
    logic [3:0]        inv;
    wire  [3:0]        out_w;
    wire  [3:0]        oe_w;

    function automatic logic is_full(input logic [1:0] c);
        return (c == ebp_pkg::CFG_FWD) || (c == ebp_pkg::CFG_REV);
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        return (a == ebp_pkg::ADDR_DUTY) || (a == ebp_pkg::ADDR_CTRL) ||
               (a == ebp_pkg::ADDR_PER) || (a == ebp_pkg::ADDR_TCON) ||
               (a == ebp_pkg::ADDR_DBAND) || (a == ebp_pkg::ADDR_SHADOW) ||
               (a == ebp_pkg::ADDR_TIMER);
    endfunction

    function automatic logic [31:0] rd_word(input logic [7:0] a);
        unique case (a)
            ebp_pkg::ADDR_DUTY:   return 32'(duty_high_q);
            ebp_pkg::ADDR_CTRL:   return 32'(ctrl_q);
            ebp_pkg::ADDR_PER:    return 32'(period_q);
            ebp_pkg::ADDR_TCON:   return 32'(tcon_q);
            ebp_pkg::ADDR_DBAND:  return 32'(dband_q);
            ebp_pkg::ADDR_SHADOW: return 32'(shadow_q);
            ebp_pkg::ADDR_TIMER:  return 32'(timer);
            default:              return '0;
        endcase
    endfunction

    // bus slave: answer registered in setup, ready in the access cycle
    assign wr_en = psel && penable && pready_q && pwrite;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !reg_hit(paddr);
            if (psel && !penable) begin
                prdata_q <= rd_word(paddr);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            duty_high_q <= ebp_pkg::RST_BYTE;
            ctrl_q      <= ebp_pkg::RST_BYTE;
            period_q    <= ebp_pkg::RST_BYTE;
            tcon_q      <= ebp_pkg::RST_TCON;
            dband_q     <= ebp_pkg::RST_BYTE;
        end else if (wr_en) begin
            unique case (paddr)
                ebp_pkg::ADDR_DUTY:  duty_high_q <= pwdata[7:0];
                ebp_pkg::ADDR_CTRL:  ctrl_q      <= pwdata[7:0];
                ebp_pkg::ADDR_PER:   period_q    <= pwdata[7:0];
                ebp_pkg::ADDR_TCON:  tcon_q      <= pwdata[2:0];
                ebp_pkg::ADDR_DBAND: dband_q     <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    ebp_period_timer u_timer (
        .clk             (clk),
        .rstn            (rstn),
        .run             (tcon_q[ebp_pkg::TCON_RUN]),
        .prescale_select (tcon_q[ebp_pkg::TCON_PS_HI:0]),
        .period_limit    (period_q),
        .timer_q         (timer),
        .sub             (sub),
        .last_tick       (last_tick),
        .period_start_q  (pstart)
    );

    assign pwm_sel   = ctrl_q[ebp_pkg::CTRL_MODE_HI:ebp_pkg::CTRL_MODE_LO]
                       == ebp_pkg::MODE_PWM;
    assign pwm_on    = pwm_sel && (mode_act_q[ebp_pkg::CTRL_MODE_HI:
                       ebp_pkg::CTRL_MODE_LO] == ebp_pkg::MODE_PWM);
    assign duty_next = {duty_high_q,
                        ctrl_q[ebp_pkg::CTRL_DLO_HI:ebp_pkg::CTRL_DLO_LO]};
    assign duty_ext  = {shadow_q, lsb_q};
    assign cnt_ext   = {timer, sub};
    assign duty_match = duty_ext == cnt_ext;

    // double buffer: duty, configuration and mode move over at the period boundary
    always_ff @(posedge clk) begin
        if (!rstn) begin
            shadow_q   <= ebp_pkg::RST_BYTE;
            lsb_q      <= '0;
            cfg_act_q  <= ebp_pkg::CFG_SINGLE;
            mode_act_q <= '0;
        end else if (pstart) begin
            shadow_q   <= duty_high_q;
            lsb_q      <= duty_next[1:0];
            cfg_act_q  <= ebp_pkg::ebp_cfg_e'(ctrl_q[ebp_pkg::CTRL_DIR:
                          ebp_pkg::CTRL_CFG_LO]);
            mode_act_q <= ctrl_q[ebp_pkg::CTRL_MODE_HI:0];
        end else if (wr_en && paddr == ebp_pkg::ADDR_SHADOW && !pwm_sel) begin
            shadow_q   <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dband_act_q <= '0;
        end else if (pstart || (duty_match && raw_q)) begin
            dband_act_q <= dband_q[ebp_pkg::DB_HI:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            raw_q <= 1'b0;
        end else if (pstart) begin
            raw_q <= duty_next != '0;
        end else if (duty_match) begin
            raw_q <= 1'b0;
        end
    end

    // pending direction change between two full-bridge configurations, true in any timer tick; early_q samples it only at last_tick
    assign fb_turn = is_full(cfg_act_q) &&
                     is_full(ctrl_q[ebp_pkg::CTRL_DIR:ebp_pkg::CTRL_CFG_LO]) &&
                     (ctrl_q[ebp_pkg::CTRL_DIR] != cfg_act_q[1]);

    always_ff @(posedge clk) begin
        if (!rstn || pstart) begin
            early_q <= 1'b0;
        end else if (last_tick && fb_turn && pwm_on) begin
            early_q <= 1'b1;
        end
    end

    ebp_deadband u_db_a (
        .clk      (clk),
        .rstn     (rstn),
        .in_level (raw_q),
        .count    (dband_act_q),
        .out_q    (db_a)
    );

    ebp_deadband u_db_b (
        .clk      (clk),
        .rstn     (rstn),
        .in_level (!raw_q),
        .count    (dband_act_q),
        .out_q    (db_b)
    );

    // channel order: 0 = A, 1 = B, 2 = C, 3 = D
    always_comb begin
        lvl = '0;
        en  = '0;
        if (pwm_on) begin
            unique case (cfg_act_q)
                ebp_pkg::CFG_SINGLE: begin
                    lvl[0] = raw_q;
                    en[0]  = 1'b1;
                end
                ebp_pkg::CFG_HALF: begin
                    lvl[0] = db_a;
                    lvl[1] = db_b;
                    en[0]  = 1'b1;
                    en[1]  = 1'b1;
                end
                ebp_pkg::CFG_FWD, ebp_pkg::CFG_REV: begin
                    en = '1;
                    if (early_q) begin
                        lvl[0] = !ctrl_q[ebp_pkg::CTRL_DIR];
                        lvl[2] = ctrl_q[ebp_pkg::CTRL_DIR];
                    end else if (cfg_act_q == ebp_pkg::CFG_FWD) begin
                        lvl[0] = 1'b1;
                        lvl[3] = raw_q;
                    end else begin
                        lvl[2] = 1'b1;
                        lvl[1] = raw_q;
                    end
                end
            endcase
        end
    end

    assign inv = {mode_act_q[ebp_pkg::CTRL_POL_BD],
                  mode_act_q[ebp_pkg::CTRL_POL_AC],
                  mode_act_q[ebp_pkg::CTRL_POL_BD],
                  mode_act_q[ebp_pkg::CTRL_POL_AC]};

    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic o_q;
        logic e_q;
        always_ff @(posedge clk) begin
            if (!rstn) begin
                o_q <= 1'b0;
                e_q <= 1'b0;
            end else begin
                o_q <= en[i] && (lvl[i] ^ inv[i]);
                e_q <= en[i];
            end
        end
        assign out_w[i] = o_q;
        assign oe_w[i]  = e_q;
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign pwm_out_a = out_w[0];
    assign pwm_out_b = out_w[1];
    assign pwm_out_c = out_w[2];
    assign pwm_out_d = out_w[3];
    assign pwm_oe_a  = oe_w[0];
    assign pwm_oe_b  = oe_w[1];
    assign pwm_oe_c  = oe_w[2];
    assign pwm_oe_d  = oe_w[3];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_shadow_load;
        pstart |=> shadow_q == $past(duty_high_q);
    endproperty
    a_shadow_load: assert property (p_shadow_load)
        else $error("shadow not loaded at period start");

    property p_shadow_ro;
        pwm_sel && !pstart |=> $stable(shadow_q);
    endproperty
    a_shadow_ro: assert property (p_shadow_ro)
        else $error("shadow changed outside period start in pwm mode");

    property p_zero_duty;
        pstart && duty_next == '0 |=> !raw_q;
    endproperty
    a_zero_duty: assert property (p_zero_duty)
        else $error("output set with zero duty");

    property p_match_clear;
        raw_q && duty_match && !pstart |=> !raw_q;
    endproperty
    a_match_clear: assert property (p_match_clear)
        else $error("output not cleared on duty match");

    property p_half_gap;
        cfg_act_q == ebp_pkg::CFG_HALF && pwm_on ##1
            $stable(mode_act_q) && mode_act_q[1:0] == '0 |->
            !(pwm_out_a && pwm_out_b);
    endproperty
    a_half_gap: assert property (p_half_gap)
        else $error("half-bridge outputs active together");

    property p_fwd_hold;
        cfg_act_q == ebp_pkg::CFG_FWD && pwm_on && !early_q &&
            mode_act_q[1:0] == '0 |=> pwm_out_a && !pwm_out_b && !pwm_out_c;
    endproperty
    a_fwd_hold: assert property (p_fwd_hold)
        else $error("forward unmodulated outputs wrong");

    property p_early_blank;
        early_q && mode_act_q[1:0] == '0 |=> !pwm_out_b && !pwm_out_d;
    endproperty
    a_early_blank: assert property (p_early_blank)
        else $error("modulated outputs active during direction switch");

    property p_early_when;
        $rose(early_q) |-> $past(last_tick) && $past(fb_turn);
    endproperty
    a_early_when: assert property (p_early_when)
        else $error("direction switch outside last tick");

    property p_release;
        !pwm_on |=> !pwm_oe_a && !pwm_oe_b && !pwm_oe_c && !pwm_oe_d;
    endproperty
    a_release: assert property (p_release)
        else $error("pin driven while pwm off");
endmodule
`default_nettype wire

// ### hw/ebp_pkg.sv
`default_nettype none
package ebp_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] ADDR_DUTY   = 8'h00;
    localparam logic [7:0] ADDR_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_PER    = 8'h08;
    localparam logic [7:0] ADDR_TCON   = 8'h0C;
    localparam logic [7:0] ADDR_DBAND  = 8'h10;
    localparam logic [7:0] ADDR_SHADOW = 8'h14;
    localparam logic [7:0] ADDR_TIMER  = 8'h18;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_TCON = 3'h0;

    // pwm_control_reg fields
    localparam int CTRL_DIR     = 7;
    localparam int CTRL_CFG_LO  = 6;
    localparam int CTRL_DLO_HI  = 5;
    localparam int CTRL_DLO_LO  = 4;
    localparam int CTRL_MODE_HI = 3;
    localparam int CTRL_MODE_LO = 2;
    localparam int CTRL_POL_AC  = 1;
    localparam int CTRL_POL_BD  = 0;
    localparam logic [1:0] MODE_PWM = 2'h3;

    // period_timer_control fields
    localparam int TCON_RUN = 2;
    localparam int TCON_PS_HI = 1;

    // prescale_select codes and fine counter terminal values
    localparam logic [1:0] PS_1  = 2'h0;
    localparam logic [1:0] PS_4  = 2'h1;
    localparam logic [5:0] TERM_1  = 6'h03;
    localparam logic [5:0] TERM_4  = 6'h0F;
    localparam logic [5:0] TERM_16 = 6'h3F;

    // deadband_count field, one step is four clocks
    localparam int DB_HI    = 6;
    localparam int DB_SHIFT = 2;

    typedef enum logic [1:0] {
        CFG_SINGLE = 2'b00,
        CFG_FWD    = 2'b01,
        CFG_HALF   = 2'b10,
        CFG_REV    = 2'b11
    } ebp_cfg_e;
endpackage
`default_nettype wire

// ### hw/ebp_period_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ebp_period_timer (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic [1:0] prescale_select,
    input  wire logic [7:0] period_limit,
    output logic      [7:0] timer_q,
    output logic      [1:0] sub,
    output logic            last_tick,
    output logic            period_start_q
);
    logic [5:0] cnt_q;
    logic [5:0] term;
    logic       wrap;

    // fine count spans four clocks times the prescale ratio
    always_comb begin
        unique case (prescale_select)
            ebp_pkg::PS_1: begin
                term = ebp_pkg::TERM_1;
                sub  = cnt_q[1:0];
            end
            ebp_pkg::PS_4: begin
                term = ebp_pkg::TERM_4;
                sub  = cnt_q[3:2];
            end
            default: begin
                term = ebp_pkg::TERM_16;
                sub  = cnt_q[5:4];
            end
        endcase
    end

    assign wrap      = run && (cnt_q == term);
    assign last_tick = run && (timer_q == period_limit);

    always_ff @(posedge clk) begin
        if (!rstn || !run || wrap) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer_q <= ebp_pkg::RST_BYTE;
        end else if (wrap) begin
            timer_q <= (timer_q == period_limit) ? ebp_pkg::RST_BYTE
                                                 : timer_q + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            period_start_q <= 1'b0;
        end else begin
            period_start_q <= wrap && (timer_q == period_limit);
        end
    end
endmodule
`default_nettype wire

// ### hw/ebp_deadband.sv
`timescale 1ns/1ps
`default_nettype none
module ebp_deadband (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       in_level,
    input  wire logic [6:0] count,
    output logic            out_q
);
    logic [8:0] wait_q;
    logic [8:0] target;

    assign target = 9'(count) << ebp_pkg::DB_SHIFT;

    // rising edge waits, falling edge passes at once; a short pulse
    // that ends before the wait is over never shows
    always_ff @(posedge clk) begin
        if (!rstn || !in_level) begin
            out_q  <= 1'b0;
            wait_q <= '0;
        end else if (wait_q == target) begin
            out_q  <= 1'b1;
        end else begin
            wait_q <= wait_q + 9'h001;
        end
    end
endmodule
`default_nettype wire

// ### tb/ebp_bridge_load.sv
`timescale 1ns/1ps
`default_nettype none
module ebp_bridge_load (
    input  wire logic [3:0] out,
    input  wire logic [3:0] oe,
    output logic      [3:0] pin
);
    // a released pin falls to the gate pull-down, so its switch stays off
    assign pin = out & oe;
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {
        logic [7:0] ctrl;
        logic [7:0] duty;
        logic [2:0] tcon;
        logic [7:0] db;
        int         a;
        int         b;
        int         c;
        int         d;
        logic [3:0] oe;
    } ebp_row_s;

    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  out;
    logic [3:0]  oe;
    logic [3:0]  pin;
    logic [31:0] rd;
    logic        er;
    int          err_total = 0;
    int          tests_run = 0;
    int          cnt[4];
    int          shoot;
    int          unk;
    // control, duty, timer control and deadband per case; limit 3
    ebp_row_s rows[13] = '{
        '{8'h2C, 8'h01, 3'h4, 8'h00, 6, 0, 0, 0, 4'h1},
        '{8'h2C, 8'h01, 3'h5, 8'h00, 24, 0, 0, 0, 4'h1},
        '{8'h2C, 8'h01, 3'h6, 8'h00, 96, 0, 0, 0, 4'h1},
        '{8'h2C, 8'hFF, 3'h4, 8'h00, 16, 0, 0, 0, 4'h1},
        '{8'h0C, 8'h00, 3'h4, 8'h00, 0, 0, 0, 0, 4'h1},
        '{8'h2E, 8'h01, 3'h4, 8'h00, 10, 0, 0, 0, 4'h1},
        '{8'h8C, 8'h02, 3'h4, 8'h01, 4, 4, 0, 0, 4'h3},
        '{8'h8C, 8'h02, 3'h4, 8'h03, 0, 0, 0, 0, 4'h3},
        '{8'h8D, 8'h02, 3'h4, 8'h01, 4, 12, 0, 0, 4'h3},
        '{8'h4C, 8'h02, 3'h4, 8'h03, 16, 0, 0, 8, 4'hF},
        '{8'hCC, 8'h02, 3'h4, 8'h03, 0, 8, 16, 0, 4'hF},
        '{8'hCF, 8'h02, 3'h4, 8'h03, 16, 8, 0, 16, 4'hF},
        '{8'h00, 8'h02, 3'h4, 8'h00, 0, 0, 0, 0, 4'h0}
    };
    logic [7:0]  ra[7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h0C, 8'h1C};
    logic [7:0]  rw[7] = '{8'hA5, 8'h30, 8'h3C, 8'hFF, 8'h12, 8'hFF, 8'hFF};
    logic [7:0]  rx[7] = '{8'hA5, 8'h30, 8'h3C, 8'hFF, 8'h12, 8'h07, 8'h00};

    always #10 clk = ~clk;

    ebp_pwm DUT (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .pwm_out_a(out[0]), .pwm_out_b(out[1]), .pwm_out_c(out[2]),
        .pwm_out_d(out[3]), .pwm_oe_a(oe[0]), .pwm_oe_b(oe[1]),
        .pwm_oe_c(oe[2]), .pwm_oe_d(oe[3])
    );
    ebp_bridge_load u_load (.out(out), .oe(oe), .pin(pin));

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_total++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, {24'h0, exp});
    endtask

    // polls the period_timer until it reads v
    task automatic wait_timer(input logic [7:0] v);
        int k;
        k = 0;
        do begin
            apb(1'b0, ebp_pkg::ADDR_TIMER, 32'h0);
            k++;
        end while (rd[7:0] !== v && k < 200);
        check({31'h0, k < 200}, 32'h1);
    endtask

    task automatic measure(input int n);
        cnt = '{0, 0, 0, 0};
        shoot = 0;
        unk = 0;
        repeat (n) begin
            @(posedge clk);
            for (int i = 0; i < 4; i++) cnt[i] += int'(pin[i]);
            shoot += int'((pin[0] & pin[1]) | (pin[2] & pin[3]));
            unk += int'($isunknown(pin));
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial begin
        int tc;
        int tb;
        int bad;
        int n;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rdchk(ra[i], 8'h00);
            wr(ra[i], rw[i]);
            rdchk(ra[i], rx[i]);
            check({31'h0, er}, {31'h0, ra[i] == 8'h1C});
        end
        $display("register test done");
        wr(ebp_pkg::ADDR_PER, 8'h03);
        foreach (rows[i]) begin
            wr(ebp_pkg::ADDR_DUTY, rows[i].duty);
            wr(ebp_pkg::ADDR_CTRL, rows[i].ctrl);
            wr(ebp_pkg::ADDR_DBAND, rows[i].db);
            wr(ebp_pkg::ADDR_TCON, {5'h0, rows[i].tcon});
            repeat (600) @(posedge clk);
            n = rows[i].tcon[1] ? 16 : (rows[i].tcon[0] ? 4 : 1);
            measure(16 * n);
            check(cnt[0], rows[i].a);
            check(cnt[1], rows[i].b);
            check(cnt[2], rows[i].c);
            check(cnt[3], rows[i].d);
            check({28'h0, oe}, {28'h0, rows[i].oe});
            check(unk, 0);
            if (rows[i].ctrl[1:0] == 2'h0) check(shoot, 0);
            $display("case %0d done", i);
        end
        // double-buffered duty, aligned to a period start
        wr(ebp_pkg::ADDR_CTRL, 8'h0C);
        wr(ebp_pkg::ADDR_DUTY, 8'h01);
        wr(ebp_pkg::ADDR_TCON, 8'h06);
        repeat (600) @(posedge clk);
        rdchk(ebp_pkg::ADDR_SHADOW, 8'h01);
        wait_timer(8'h03);
        wait_timer(8'h00);
        wr(ebp_pkg::ADDR_DUTY, 8'h07);
        wr(ebp_pkg::ADDR_SHADOW, 8'h33);
        rdchk(ebp_pkg::ADDR_SHADOW, 8'h01);
        repeat (300) @(posedge clk);
        rdchk(ebp_pkg::ADDR_SHADOW, 8'h07);
        $display("shadow test done");
        // forward to reverse at prescale 4 with a deadband set
        wr(ebp_pkg::ADDR_DUTY, 8'h02);
        wr(ebp_pkg::ADDR_DBAND, 8'h03);
        wr(ebp_pkg::ADDR_CTRL, 8'h4C);
        wr(ebp_pkg::ADDR_TCON, 8'h05);
        repeat (600) @(posedge clk);
        // turn early in the period, well before its last timer tick
        wait_timer(8'h00);
        wr(ebp_pkg::ADDR_CTRL, 8'hCC);
        tc = -1;
        tb = -1;
        bad = 0;
        for (int t = 0; t < 300; t++) begin
            @(posedge clk);
            if (tc < 0 && pin[2]) tc = t;
            if (tc >= 0 && tb < 0 && pin[1]) tb = t;
            if (tc >= 0 && tb < 0 && (pin[0] | pin[3])) bad++;
        end
        check(bad, 0);
        check({31'h0, tc >= 0 && tb - tc >= 16 && tb - tc <= 18}, 1);
        $display("direction test done");
        rstn <= 1'b0;
        repeat (10) @(posedge clk);
        check({24'h0, out, oe}, 32'h0);
        rstn <= 1'b1;
        rdchk(ebp_pkg::ADDR_CTRL, 8'h00);
        $display("reset test done");
        stop_test();
    end
endmodule
`default_nettype wire
